// [rtl/lcr_cycle_timer.sv]
// Isochronous cycle timer: offset, cycle count and seconds with load and rollover pulse.
`timescale 1ns/1ps
`default_nettype none
module lcr_cycle_timer #(
	parameter int REF_KHZ = lcr_pkg::REF_CLK_KHZ,
	parameter int SYS_KHZ = lcr_pkg::SYS_CLK_KHZ
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        count_en,
	input  wire logic        load_valid,
	input  wire logic [31:0] load_value,
	output var  logic [31:0] cycle_time_r,
	output var  logic        rollover_r
);

	localparam logic [16:0] PH_STEP = 17'(REF_KHZ);
	localparam logic [16:0] PH_WRAP = 17'(SYS_KHZ);

	logic [16:0] phase_r;
	logic [16:0] phase_sum;
	logic        ref_tick;
	logic [11:0] offset;
	logic [12:0] count;
	logic [6:0]  seconds;

	assign offset  = cycle_time_r[11:0];
	assign count   = cycle_time_r[24:12];
	assign seconds = cycle_time_r[31:25];

	// Phase accumulator turns the system clock into reference-clock ticks, at most one per cycle.
	assign phase_sum = phase_r + PH_STEP;
	assign ref_tick  = count_en && (phase_sum >= PH_WRAP);

	// The phase only advances while counting so a stopped timer resumes where it left off.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			phase_r <= 17'h00000;
		end else if (count_en) begin
			phase_r <= ref_tick ? 17'(phase_sum - PH_WRAP) : phase_sum;
		end
	end

	// Each field advances on the rollover of the field below; a load overrides counting.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cycle_time_r <= lcr_pkg::CT_RESET;
			rollover_r   <= 1'b0;
		end else if (load_valid) begin
			cycle_time_r <= load_value;
			rollover_r   <= 1'b0;
		end else if (ref_tick) begin
			if (offset == lcr_pkg::CT_OFFSET_MAX) begin
				cycle_time_r[11:0] <= 12'h000;
				rollover_r         <= 1'b1;
				if (count == lcr_pkg::CT_COUNT_MAX) begin
					cycle_time_r[24:12] <= 13'h0000;
					cycle_time_r[31:25] <= (seconds == lcr_pkg::CT_SEC_MAX) ? 7'h00 : 7'(seconds + 7'h01);
				end else begin
					cycle_time_r[24:12] <= 13'(count + 13'h0001);
				end
			end else begin
				cycle_time_r[11:0] <= 12'(offset + 12'h001);
				rollover_r         <= 1'b0;
			end
		end else begin
			rollover_r <= 1'b0;
		end
	end

endmodule : lcr_cycle_timer
`default_nettype wire

// [rtl/lcr_link_ctrl.sv]
// Link control register bank with Avalon-MM slave, receive gating and cycle start control.
//
// Operation
// - Reserved ranges 31:23, 19:11 and 5:0 always read back zero.
// - External cycle source bit 22 always reads zero; no external timer input.
// - Cycle master and root: send cycle start on every cycle timer rollover.
// - Not cycle master: received cycle starts reload the local cycle timer.
// - Cycle master bit drops automatically when the overlong cycle flag is set.
// - Setting cycle master is ignored while the overlong cycle flag stays set.
// - Count enable set: offset advances per reference tick, fields roll over.
// - Count enable clear: the cycle offset holds still unless a received cycle start reloads it.
// - PHY packets go to request context when enabled and context is running.
// - Self-ID packets outside the self-ID phase ignore the PHY packet bit.
// - Self-ID packets accepted only while the self-ID accept bit is set.
// - Lock set forces every receive context tag one filter to read one.
// - Lock is set-only, cleared by hardware reset, kept over soft reset.
// - Two word addresses decoded: one sets bits, one clears bits.
// - Only ones at the clear address clear; zeros anywhere change nothing.
// - Timer counts offset mod 3072, cycles mod 8000, seconds mod 128.
`timescale 1ns/1ps
`default_nettype none
module lcr_link_ctrl #(
	parameter int REF_KHZ = lcr_pkg::REF_CLK_KHZ,
	parameter int SYS_KHZ = lcr_pkg::SYS_CLK_KHZ
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        soft_rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	input  wire logic        phy_is_root,
	input  wire logic        overlong_cycle_flag,
	input  wire logic        rx_cycle_start_valid,
	input  wire logic [31:0] rx_cycle_start_data,
	input  wire logic        rx_pkt_valid,
	input  wire logic        rx_pkt_is_phy,
	input  wire logic        rx_pkt_is_self_id,
	input  wire logic        self_id_phase,
	input  wire logic        ar_req_ctx_enabled,
	output var  logic        cycle_start_generator_enable,
	output var  logic        cycle_offset_count_enable,
	output var  logic        accept_phy_packets,
	output var  logic        accept_self_id_packets,
	output var  logic        tag_one_filter_lock,
	output var  logic        tag_one_sync_filter_force,
	output var  logic        cycle_start_tx,
	output var  logic [31:0] cycle_time,
	output var  logic        phy_pkt_to_ar,
	output var  logic        self_id_accept,
	output var  logic        stray_self_id
);

	lcr_pkg::lcr_bus_state_t bus_state_r;
	lcr_pkg::lcr_bus_state_t bus_state_nxt;

	logic        waitrequest_r;
	logic [31:0] readdata_r;
	logic        master_r;
	logic        cnt_en_r;
	logic        acc_phy_r;
	logic        acc_self_id_r;
	logic        tag_lock_r;
	logic        tag_force_r;
	logic        cyc_tx_r;
	logic        phy_to_ar_r;
	logic        self_id_acc_r;
	logic        stray_self_id_r;
	logic [31:0] timer_value;
	logic        timer_rollover;
	logic        wr_take;
	logic [31:0] wr_bits;
	logic [31:0] set_bits;
	logic [31:0] clr_bits;
	logic        timer_load;

	// Expands byte enables into a bit mask.
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_mask

	// Builds the link control word from the stored bits; unstored bits stay zero.
	function automatic logic [31:0] link_word(input logic m, input logic c, input logic p,
			input logic s, input logic l);
		logic [31:0] w;
		w                           = 32'h0000_0000;
		w[lcr_pkg::BIT_CYC_MASTER]  = m;
		w[lcr_pkg::BIT_CYC_CNT_EN]  = c;
		w[lcr_pkg::BIT_ACC_PHY]     = p;
		w[lcr_pkg::BIT_ACC_SELF_ID] = s;
		w[lcr_pkg::BIT_TAG_LOCK]    = l;
		link_word                   = w & lcr_pkg::LINK_STORED_MASK;
	endfunction : link_word

	// True for either of the two decoded addresses.
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == lcr_pkg::OFS_LINK_SET) || (a == lcr_pkg::OFS_LINK_CLR);
	endfunction : is_mapped

	// Outputs come straight from flip-flops.
	assign avs_readdata                 = readdata_r;
	assign avs_waitrequest              = waitrequest_r;
	assign cycle_start_generator_enable = master_r;
	assign cycle_offset_count_enable    = cnt_en_r;
	assign accept_phy_packets           = acc_phy_r;
	assign accept_self_id_packets       = acc_self_id_r;
	assign tag_one_filter_lock          = tag_lock_r;
	assign tag_one_sync_filter_force    = tag_force_r;
	assign cycle_start_tx               = cyc_tx_r;
	assign cycle_time                   = timer_value;
	assign phy_pkt_to_ar                = phy_to_ar_r;
	assign self_id_accept               = self_id_acc_r;
	assign stray_self_id                = stray_self_id_r;

	// A write takes effect on the edge where waitrequest is seen low.
	assign wr_take  = avs_write && (bus_state_r == lcr_pkg::LCR_BUS_ACK);
	assign wr_bits  = avs_writedata & be_mask(avs_byteenable) & lcr_pkg::LINK_STORED_MASK;
	assign set_bits = (wr_take && (avs_address == lcr_pkg::OFS_LINK_SET)) ? wr_bits : 32'h0000_0000;
	assign clr_bits = (wr_take && (avs_address == lcr_pkg::OFS_LINK_CLR)) ? wr_bits : 32'h0000_0000;

	// Two-state handshake: a request is answered one cycle after it appears.
	always_comb begin
		case (bus_state_r)
			lcr_pkg::LCR_BUS_IDLE: bus_state_nxt = (avs_read || avs_write) ? lcr_pkg::LCR_BUS_ACK
				: lcr_pkg::LCR_BUS_IDLE;
			lcr_pkg::LCR_BUS_ACK:  bus_state_nxt = lcr_pkg::LCR_BUS_IDLE;
			default:               bus_state_nxt = lcr_pkg::LCR_BUS_IDLE;
		endcase
	end

	// Bus state and waitrequest; waitrequest is high except in the answer cycle.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bus_state_r   <= lcr_pkg::LCR_BUS_IDLE;
			waitrequest_r <= 1'b1;
		end else begin
			bus_state_r   <= bus_state_nxt;
			waitrequest_r <= (bus_state_nxt != lcr_pkg::LCR_BUS_ACK);
		end
	end

	// Read data is captured as the answer opens; both addresses show the same word.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			readdata_r <= 32'h0000_0000;
		end else if ((bus_state_r == lcr_pkg::LCR_BUS_IDLE) && avs_read) begin
			readdata_r <= is_mapped(avs_address)
				? link_word(master_r, cnt_en_r, acc_phy_r, acc_self_id_r, tag_lock_r)
				: lcr_pkg::UNMAPPED_READ;
		end
	end

	// Cycle master bit; the overlong flag forces it low and blocks any set.
	always_ff @(posedge clk_sys) begin
		if (srst || soft_rst) begin
			master_r <= lcr_pkg::LINK_BIT_RESET;
		end else if (overlong_cycle_flag) begin
			master_r <= 1'b0;
		end else if (set_bits[lcr_pkg::BIT_CYC_MASTER]) begin
			master_r <= 1'b1;
		end else if (clr_bits[lcr_pkg::BIT_CYC_MASTER]) begin
			master_r <= 1'b0;
		end
	end

	// Plain set/clear bits; only a one at the clear address clears.
	always_ff @(posedge clk_sys) begin
		if (srst || soft_rst) begin
			cnt_en_r      <= lcr_pkg::LINK_BIT_RESET;
			acc_phy_r     <= lcr_pkg::LINK_BIT_RESET;
			acc_self_id_r <= lcr_pkg::LINK_BIT_RESET;
		end else begin
			cnt_en_r      <= (cnt_en_r | set_bits[lcr_pkg::BIT_CYC_CNT_EN])
				& ~clr_bits[lcr_pkg::BIT_CYC_CNT_EN];
			acc_phy_r     <= (acc_phy_r | set_bits[lcr_pkg::BIT_ACC_PHY])
				& ~clr_bits[lcr_pkg::BIT_ACC_PHY];
			acc_self_id_r <= (acc_self_id_r | set_bits[lcr_pkg::BIT_ACC_SELF_ID])
				& ~clr_bits[lcr_pkg::BIT_ACC_SELF_ID];
		end
	end

	// Filter lock only sets; soft reset and the clear address leave it alone.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tag_lock_r  <= 1'b0;
			tag_force_r <= 1'b0;
		end else begin
			tag_lock_r  <= tag_lock_r | set_bits[lcr_pkg::BIT_TAG_LOCK];
			tag_force_r <= tag_lock_r | set_bits[lcr_pkg::BIT_TAG_LOCK];
		end
	end

	// Received cycle starts resynchronise the timer only when not cycle master.
	assign timer_load = rx_cycle_start_valid && !master_r;

	lcr_cycle_timer #(
		.REF_KHZ (REF_KHZ),
		.SYS_KHZ (SYS_KHZ)
	) u_timer (
		.clk_sys      (clk_sys),
		.srst         (srst),
		.count_en     (cnt_en_r),
		.load_valid   (timer_load),
		.load_value   (rx_cycle_start_data),
		.cycle_time_r (timer_value),
		.rollover_r   (timer_rollover)
	);

	// Cycle start is requested on each rollover while master and root.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cyc_tx_r <= 1'b0;
		end else begin
			cyc_tx_r <= timer_rollover && master_r && phy_is_root;
		end
	end

	// Receive gating of PHY and self-ID packets.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			phy_to_ar_r     <= 1'b0;
			self_id_acc_r   <= 1'b0;
			stray_self_id_r <= 1'b0;
		end else begin
			phy_to_ar_r     <= rx_pkt_valid && rx_pkt_is_phy && acc_phy_r && ar_req_ctx_enabled;
			self_id_acc_r   <= rx_pkt_valid && rx_pkt_is_self_id && self_id_phase && acc_self_id_r;
			stray_self_id_r <= rx_pkt_valid && rx_pkt_is_self_id && !self_id_phase;
		end
	end

	// Checks on the bank's behaviour.
	property p_reserved_zero;
		@(posedge clk_sys) disable iff (srst)
		(!avs_waitrequest && avs_read) |-> ((avs_readdata & ~lcr_pkg::LINK_STORED_MASK) == 32'h0000_0000);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

	property p_ext_sel_zero;
		@(posedge clk_sys) disable iff (srst)
		!avs_waitrequest |-> !avs_readdata[lcr_pkg::BIT_EXT_CYC_SEL];
	endproperty
	a_ext_sel_zero: assert property (p_ext_sel_zero) else $error("external cycle select reads one");

	property p_cycle_start;
		@(posedge clk_sys) disable iff (srst)
		(timer_rollover && master_r && phy_is_root) |=> cycle_start_tx;
	endproperty
	a_cycle_start: assert property (p_cycle_start) else $error("cycle start missing on rollover");

	property p_resync;
		@(posedge clk_sys) disable iff (srst)
		(rx_cycle_start_valid && !master_r) |=> (cycle_time == $past(rx_cycle_start_data));
	endproperty
	a_resync: assert property (p_resync) else $error("timer not loaded from cycle start");

	property p_overlong_clears;
		@(posedge clk_sys) disable iff (srst)
		overlong_cycle_flag |=> !cycle_start_generator_enable;
	endproperty
	a_overlong_clears: assert property (p_overlong_clears) else $error("master kept with overlong flag");

	property p_no_set_overlong;
		@(posedge clk_sys) disable iff (srst)
		$rose(master_r) |-> !$past(overlong_cycle_flag);
	endproperty
	a_no_set_overlong: assert property (p_no_set_overlong) else $error("master set during overlong");

	property p_offset_counts;
		@(posedge clk_sys) disable iff (srst)
		(cnt_en_r && !timer_load ##1 cnt_en_r && !timer_load) |=> (cycle_time[11:0] != $past(cycle_time[11:0], 2));
	endproperty
	a_offset_counts: assert property (p_offset_counts) else $error("offset not advancing");

	property p_offset_holds;
		@(posedge clk_sys) disable iff (srst)
		(!cnt_en_r && !timer_load) |=> $stable(cycle_time);
	endproperty
	a_offset_holds: assert property (p_offset_holds) else $error("offset moved while disabled");

	property p_phy_route;
		@(posedge clk_sys) disable iff (srst)
		(rx_pkt_valid && rx_pkt_is_phy) |=> (phy_pkt_to_ar == $past(acc_phy_r && ar_req_ctx_enabled));
	endproperty
	a_phy_route: assert property (p_phy_route) else $error("PHY packet routing wrong");

	property p_self_id_gate;
		@(posedge clk_sys) disable iff (srst)
		(rx_pkt_valid && rx_pkt_is_self_id && self_id_phase) |=> (self_id_accept == $past(acc_self_id_r));
	endproperty
	a_self_id_gate: assert property (p_self_id_gate) else $error("self-ID acceptance wrong");

	property p_lock_force;
		@(posedge clk_sys) disable iff (srst)
		tag_one_filter_lock |-> tag_one_sync_filter_force;
	endproperty
	a_lock_force: assert property (p_lock_force) else $error("filter not forced under lock");

	property p_lock_sticky;
		@(posedge clk_sys) disable iff (srst)
		tag_one_filter_lock |=> tag_one_filter_lock;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared without reset");

	property p_zero_keeps;
		@(posedge clk_sys) disable iff (srst)
		(wr_take && !soft_rst && cnt_en_r && !avs_writedata[lcr_pkg::BIT_CYC_CNT_EN]) |=> cnt_en_r;
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed a bit");

	property p_read_match;
		@(posedge clk_sys) disable iff (srst)
		(avs_read && bus_state_r == lcr_pkg::LCR_BUS_IDLE && is_mapped(avs_address)) |=>
			(avs_readdata[lcr_pkg::BIT_TAG_LOCK] == $past(tag_lock_r)) && !avs_waitrequest;
	endproperty
	a_read_match: assert property (p_read_match) else $error("readback differs from word");

	property p_stray_self_id;
		@(posedge clk_sys) disable iff (srst)
		(rx_pkt_valid && rx_pkt_is_self_id && !self_id_phase) |=> stray_self_id;
	endproperty
	a_stray_self_id: assert property (p_stray_self_id) else $error("stray self-ID not flagged");

	property p_set_view;
		@(posedge clk_sys) disable iff (srst)
		(wr_take && !soft_rst && (avs_address == lcr_pkg::OFS_LINK_SET) && wr_bits[lcr_pkg::BIT_ACC_PHY]) |=>
			accept_phy_packets;
	endproperty
	a_set_view: assert property (p_set_view) else $error("set address did not set bit");

	property p_clear_view;
		@(posedge clk_sys) disable iff (srst)
		(wr_take && (avs_address == lcr_pkg::OFS_LINK_CLR) && wr_bits[lcr_pkg::BIT_ACC_SELF_ID]) |=>
			!accept_self_id_packets;
	endproperty
	a_clear_view: assert property (p_clear_view) else $error("clear address did not clear bit");

	c_cycle_start: cover property (@(posedge clk_sys) disable iff (srst) cycle_start_tx);
	c_resync:      cover property (@(posedge clk_sys) disable iff (srst) timer_load);
	c_lock_set:    cover property (@(posedge clk_sys) disable iff (srst) $rose(tag_lock_r));
	c_clear_write: cover property (@(posedge clk_sys) disable iff (srst) |clr_bits);
	c_stray:       cover property (@(posedge clk_sys) disable iff (srst) stray_self_id);

endmodule : lcr_link_ctrl
`default_nettype wire

// [rtl/lcr_pkg.sv]
// Constants shared by the link control register bank and its cycle timer.
package lcr_pkg;

	// Register bus shape.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;

	// Byte addresses of the set and clear views of the link control word.
	localparam logic [7:0] OFS_LINK_SET = 8'hE0;
	localparam logic [7:0] OFS_LINK_CLR = 8'hE4;

	// Field positions inside the link control word.
	localparam int BIT_EXT_CYC_SEL = 22;
	localparam int BIT_CYC_MASTER  = 21;
	localparam int BIT_CYC_CNT_EN  = 20;
	localparam int BIT_ACC_PHY     = 10;
	localparam int BIT_ACC_SELF_ID = 9;
	localparam int BIT_TAG_LOCK    = 6;

	// Bits that are stored; everything else reads as zero.
	localparam logic [31:0] LINK_STORED_MASK = 32'h0030_0640;
	localparam logic        LINK_BIT_RESET   = 1'h0;
	localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

	// Cycle timer field layout and moduli.
	localparam int          CT_SEC_LSB    = 25;
	localparam int          CT_COUNT_LSB  = 12;
	localparam logic [11:0] CT_OFFSET_MAX = 12'hBFF;
	localparam logic [12:0] CT_COUNT_MAX  = 13'h1F3F;
	localparam logic [6:0]  CT_SEC_MAX    = 7'h7F;
	localparam logic [31:0] CT_RESET      = 32'h0000_0000;

	// Reference clock of the offset counter and the system clock, in kHz.
	localparam int SYS_PERIOD_NS = 25;
	localparam int REF_CLK_KHZ   = 24576;
	localparam int SYS_CLK_KHZ   = 1000000 / SYS_PERIOD_NS;
	localparam int PHASE_W       = 17;

	// Bus handshake states, Gray coded.
	typedef enum logic [1:0] {
		LCR_BUS_IDLE = 2'b00,
		LCR_BUS_ACK  = 2'b01
	} lcr_bus_state_t;

endpackage : lcr_pkg

// [tb/lcr_link_ctrl_tb_top.sv]
// Self-checking testbench for the link control register bank.
`timescale 1ns/1ps
`default_nettype none
module lcr_link_ctrl_tb_top;

	localparam int          REF_FAST = 39999;
	localparam logic [31:0] ALL      = 32'hFFFF_FFFF;
	localparam logic [31:0] LOADV    = {7'h05, 13'h1F3F, 12'hBFF};

	logic        clk_sys, srst, soft_rst;
	logic [7:0]  avs_address;
	logic        avs_read, avs_write;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic        avs_waitrequest;
	logic        phy_is_root, overlong_cycle_flag, rx_cycle_start_valid;
	logic [31:0] rx_cycle_start_data, cycle_time;
	logic        rx_pkt_valid, rx_pkt_is_phy, rx_pkt_is_self_id, self_id_phase, ar_req_ctx_enabled;
	logic        gen_en, cnt_en, acc_phy, acc_sid, lock, force_one;
	logic        cycle_start_tx, phy_pkt_to_ar, self_id_accept, stray_self_id;
	logic [31:0] rd;
	int          n_mismatch;
	int          cmp_count;

	// Fast reference clock so that a cycle rollover takes about 3072 system cycles.
	lcr_link_ctrl #(.REF_KHZ(REF_FAST), .SYS_KHZ(40000)) i_dut (
		.clk_sys(clk_sys), .srst(srst), .soft_rst(soft_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.phy_is_root(phy_is_root), .overlong_cycle_flag(overlong_cycle_flag),
		.rx_cycle_start_valid(rx_cycle_start_valid), .rx_cycle_start_data(rx_cycle_start_data),
		.rx_pkt_valid(rx_pkt_valid), .rx_pkt_is_phy(rx_pkt_is_phy), .rx_pkt_is_self_id(rx_pkt_is_self_id),
		.self_id_phase(self_id_phase), .ar_req_ctx_enabled(ar_req_ctx_enabled),
		.cycle_start_generator_enable(gen_en), .cycle_offset_count_enable(cnt_en),
		.accept_phy_packets(acc_phy), .accept_self_id_packets(acc_sid),
		.tag_one_filter_lock(lock), .tag_one_sync_filter_force(force_one),
		.cycle_start_tx(cycle_start_tx), .cycle_time(cycle_time),
		.phy_pkt_to_ar(phy_pkt_to_ar), .self_id_accept(self_id_accept), .stray_self_id(stray_self_id)
	);

	// System clock, 25 ns period.
	always #12.5 clk_sys = ~clk_sys;

	// Compares one value and counts the outcome.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Prints the counts and the verdict, then ends the run.
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	// One Avalon access held until waitrequest is sampled low; read data is taken at that edge.
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data, input logic [3:0] be);
		int n;
		@(posedge clk_sys);
		avs_write      <= wr;
		avs_read       <= ~wr;
		avs_address    <= addr;
		avs_writedata  <= data;
		avs_byteenable <= be;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		chk("waitrequest", {31'h0, avs_waitrequest}, 32'h0);
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus

	// Reads one address and compares with the expected word.
	task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
		bus(1'b0, addr, 32'h0, 4'hF);
		chk("readdata", rd, exp);
	endtask : rd_chk

	// Sends one classified packet and checks the three one-cycle answers.
	task automatic rx_chk(input logic phy, input logic sid, input logic ar, input logic ph, input logic [2:0] exp);
		@(posedge clk_sys);
		rx_pkt_valid       <= 1'b1;
		rx_pkt_is_phy      <= phy;
		rx_pkt_is_self_id  <= sid;
		ar_req_ctx_enabled <= ar;
		self_id_phase      <= ph;
		@(posedge clk_sys);
		rx_pkt_valid <= 1'b0;
		@(posedge clk_sys);
		chk("rx answers", {29'h0, phy_pkt_to_ar, self_id_accept, stray_self_id}, {29'h0, exp});
	endtask : rx_chk

	// Reset values, set and clear views, set-only lock.
	task automatic t_set_clear();
		rd_chk(8'hE0, 32'h0);
		rd_chk(8'hE4, 32'h0);
		bus(1'b1, 8'hE0, ALL, 4'hF);
		rd_chk(8'hE0, 32'h0030_0640);
		rd_chk(8'hE4, 32'h0030_0640);
		chk("outputs", {26'h0, gen_en, cnt_en, acc_phy, acc_sid, lock, force_one}, 32'h3F);
		bus(1'b1, 8'hE4, 32'h0, 4'hF);
		bus(1'b1, 8'hE0, 32'h0, 4'hF);
		rd_chk(8'hE0, 32'h0030_0640);
		bus(1'b1, 8'hE4, ALL, 4'hF);
		rd_chk(8'hE4, 32'h0000_0040);
		chk("filter force", {31'h0, force_one}, 32'h1);
	endtask : t_set_clear

	// Byte lanes, single-bit clear, unmapped address, soft reset.
	task automatic t_lanes_soft();
		bus(1'b1, 8'hE0, ALL, 4'b0100);
		rd_chk(8'hE0, 32'h0030_0040);
		bus(1'b1, 8'hE4, ALL, 4'b1011);
		bus(1'b1, 8'hE4, 32'h0010_0000, 4'hF);
		rd_chk(8'hE0, 32'h0020_0040);
		bus(1'b1, 8'hE8, ALL, 4'hF);
		rd_chk(8'hE8, 32'h0);
		bus(1'b1, 8'hE0, ALL, 4'hF);
		@(posedge clk_sys);
		soft_rst <= 1'b1;
		@(posedge clk_sys);
		soft_rst <= 1'b0;
		rd_chk(8'hE0, 32'h0000_0040);
	endtask : t_lanes_soft

	// Overlong cycle flag drops and blocks the cycle master bit.
	task automatic t_overlong();
		bus(1'b1, 8'hE0, 32'h0020_0000, 4'hF);
		@(posedge clk_sys);
		overlong_cycle_flag <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("master output", {31'h0, gen_en}, 32'h0);
		bus(1'b1, 8'hE0, 32'h0020_0000, 4'hF);
		rd_chk(8'hE0, 32'h0000_0040);
		overlong_cycle_flag <= 1'b0;
		bus(1'b1, 8'hE0, 32'h0020_0000, 4'hF);
		rd_chk(8'hE0, 32'h0020_0040);
		bus(1'b1, 8'hE4, 32'h0020_0000, 4'hF);
	endtask : t_overlong

	// Receive gating by the PHY and self-ID accept bits.
	task automatic t_rx();
		rx_chk(1'b1, 1'b0, 1'b1, 1'b1, 3'b000);
		rx_chk(1'b0, 1'b1, 1'b1, 1'b1, 3'b000);
		bus(1'b1, 8'hE0, 32'h0000_0600, 4'hF);
		rx_chk(1'b1, 1'b0, 1'b1, 1'b1, 3'b100);
		rx_chk(1'b1, 1'b0, 1'b0, 1'b1, 3'b000);
		rx_chk(1'b0, 1'b1, 1'b1, 1'b1, 3'b010);
		rx_chk(1'b0, 1'b1, 1'b1, 1'b0, 3'b001);
		bus(1'b1, 8'hE4, 32'h0000_0600, 4'hF);
		rx_chk(1'b0, 1'b1, 1'b1, 1'b0, 3'b001);
	endtask : t_rx

	// Timer hold, load from a received cycle start, rollover and cycle start sending.
	task automatic t_timer();
		logic [31:0] held;
		int          n;
		held = cycle_time;
		repeat (20) @(posedge clk_sys);
		chk("held time", cycle_time, held);
		rx_cycle_start_data  <= LOADV;
		rx_cycle_start_valid <= 1'b1;
		@(posedge clk_sys);
		rx_cycle_start_valid <= 1'b0;
		@(posedge clk_sys);
		chk("loaded time", cycle_time, LOADV);
		bus(1'b1, 8'hE0, 32'h0010_0000, 4'hF);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (cycle_time[11:0] === 12'hBFF && n < 20);
		chk("wrapped time", cycle_time, {7'h06, 13'h0, 12'h0});
		phy_is_root <= 1'b1;
		bus(1'b1, 8'hE0, 32'h0020_0000, 4'hF);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (cycle_start_tx !== 1'b1 && n < 3500);
		chk("start sent", {31'h0, cycle_start_tx}, 32'h1);
		@(posedge clk_sys);
		chk("start pulse", {31'h0, cycle_start_tx}, 32'h0);
		phy_is_root <= 1'b0;
		n = 0;
		repeat (3500) begin
			@(posedge clk_sys);
			if (cycle_start_tx === 1'b1)
				n++;
		end
		chk("no start off root", n, 0);
	endtask : t_timer

	// Main sequence.
	initial begin
		clk_sys = 1'b0;
		srst = 1'b1;
		soft_rst = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		phy_is_root = 1'b0;
		overlong_cycle_flag = 1'b0;
		rx_cycle_start_valid = 1'b0;
		rx_cycle_start_data = 32'h0;
		rx_pkt_valid = 1'b0;
		rx_pkt_is_phy = 1'b0;
		rx_pkt_is_self_id = 1'b0;
		self_id_phase = 1'b0;
		ar_req_ctx_enabled = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		t_set_clear();
		t_lanes_soft();
		t_overlong();
		t_rx();
		t_timer();
		conclude();
	end

	// Watchdog: the whole sequence needs well under 20000 cycles.
	initial begin
		#(25 * 20000);
		n_mismatch++;
		conclude();
	end

endmodule : lcr_link_ctrl_tb_top
`default_nettype wire
